// >>> prox_regs_pkg.sv
package prox_regs_pkg;

  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_PROX2_LOW     = 8'h13;
  localparam logic [7:0] OFS_PROX2_HIGH    = 8'h14;
  localparam logic [7:0] OFS_PROX3_LOW     = 8'h15;
  localparam logic [7:0] OFS_PROX3_HIGH    = 8'h16;
  localparam logic [7:0] OFS_PARAM_MAILBOX = 8'h17;
  localparam logic [7:0] OFS_COMMAND       = 8'h18;

  // ---------------------------------------------------------------
  // Reset values and channel codes
  // ---------------------------------------------------------------
  localparam logic [7:0] RESET_LOW     = 8'h00;
  localparam logic [7:0] RESET_HIGH    = 8'h00;
  localparam logic [7:0] RESET_PARAM   = 8'h00;
  localparam logic [7:0] RESET_COMMAND = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam logic [1:0] CHAN_TWO      = 2'h2;
  localparam logic [1:0] CHAN_THREE    = 2'h3;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        write;
    logic        read;
    logic [7:0]  addr;
    logic [7:0]  wdata;
  } reg_access_t;

  typedef struct packed {
    logic        valid;
    logic [1:0]  channel;
    logic [15:0] value;
  } measurement_t;

endpackage

// >>> prox_threshold_param_regs.sv
// What this block does
// - Channel two threshold compared to its results
// - Channel three threshold compared to its results
// - Channel two high byte at 0x14
// - Channel three bytes at 0x15, 0x16
// - Half-written threshold never reaches a comparison
// - Parameter mailbox byte at 0x17, reset zero
// - Channel two low byte at 0x13, reset zero
// - Commands delivered by writing 0x18
module prox_threshold_param_regs (
  input  wire logic                         clock,
  input  wire logic                         arst_n,
  input  wire prox_regs_pkg::reg_access_t   host,
  output logic [7:0]                        rd_data,
  output logic                              rd_valid,
  input  wire prox_regs_pkg::measurement_t  meas,
  output logic                              prox2_event,
  output logic                              prox3_event,
  output logic [15:0]                       prox2_active,
  output logic [15:0]                       prox3_active,
  output logic [7:0]                        param_value,
  output logic [7:0]                        command_code,
  output logic                              command_strobe
);

  // ---------------------------------------------------------------
  // Per-channel threshold storage
  // ---------------------------------------------------------------
  logic [7:0]  th_low    [2];
  logic [7:0]  th_high   [2];
  logic        pend_low  [2];
  logic        pend_high [2];
  logic        wr_low    [2];
  logic        wr_high   [2];
  logic        commit    [2];
  logic [15:0] active    [2];
  logic        over      [2];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      localparam logic [7:0] LOW_ADDR  = (g == 0) ?
        prox_regs_pkg::OFS_PROX2_LOW : prox_regs_pkg::OFS_PROX3_LOW;
      localparam logic [7:0] HIGH_ADDR = (g == 0) ?
        prox_regs_pkg::OFS_PROX2_HIGH : prox_regs_pkg::OFS_PROX3_HIGH;
      localparam logic [1:0] CHAN      = (g == 0) ?
        prox_regs_pkg::CHAN_TWO : prox_regs_pkg::CHAN_THREE;

      // Byte write decode
      // byte address decode
      assign wr_low[g]  = host.write && (host.addr == LOW_ADDR);
      assign wr_high[g] = host.write && (host.addr == HIGH_ADDR);
      assign commit[g]  = (wr_low[g] && pend_high[g]) ||
                          (wr_high[g] && pend_low[g]);
      assign over[g]    = meas.valid && (meas.channel == CHAN) &&
                          (meas.value > active[g]);

      // Host-visible bytes and pending marks
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          th_low[g]    <= prox_regs_pkg::RESET_LOW;
          th_high[g]   <= prox_regs_pkg::RESET_HIGH;
          pend_low[g]  <= 1'b0;
          pend_high[g] <= 1'b0;
        end else begin
          if (wr_low[g]) th_low[g] <= host.wdata;
          if (wr_high[g]) th_high[g] <= host.wdata;
          pend_low[g]  <= (wr_low[g] || pend_low[g]) && !commit[g];
          pend_high[g] <= (wr_high[g] || pend_high[g]) && !commit[g];
        end
      end

      // Committed threshold: a lone byte never reaches the comparator,
      // which closes the torn-value window at the cost of one extra
      // write when only one byte really changes.
      // atomic two-byte apply
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          active[g] <= {prox_regs_pkg::RESET_HIGH, prox_regs_pkg::RESET_LOW};
        end else if (commit[g]) begin
          active[g] <= {wr_high[g] ? host.wdata : th_high[g],
                        wr_low[g] ? host.wdata : th_low[g]};
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read decode
  // ---------------------------------------------------------------
  logic [7:0] rd_mux;
  logic       wr_param;
  logic       wr_cmd;

  assign rd_mux =
    (host.addr == prox_regs_pkg::OFS_PROX2_LOW)     ? th_low[0]    :
    (host.addr == prox_regs_pkg::OFS_PROX2_HIGH)    ? th_high[0]   :
    (host.addr == prox_regs_pkg::OFS_PROX3_LOW)     ? th_low[1]    :
    (host.addr == prox_regs_pkg::OFS_PROX3_HIGH)    ? th_high[1]   :
    (host.addr == prox_regs_pkg::OFS_PARAM_MAILBOX) ? param_value  :
    (host.addr == prox_regs_pkg::OFS_COMMAND)       ? command_code :
                                    prox_regs_pkg::READ_UNMAPPED;
  assign wr_param = host.write &&
                    (host.addr == prox_regs_pkg::OFS_PARAM_MAILBOX);
  assign wr_cmd   = host.write && (host.addr == prox_regs_pkg::OFS_COMMAND);

  // Registered read answer, one cycle after the request
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rd_data  <= prox_regs_pkg::READ_UNMAPPED;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= host.read;
      rd_data  <= host.read ? rd_mux : prox_regs_pkg::READ_UNMAPPED;
    end
  end

  // Parameter and command mailboxes
  // mailbox storage and strobe
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      param_value    <= prox_regs_pkg::RESET_PARAM;
      command_code   <= prox_regs_pkg::RESET_COMMAND;
      command_strobe <= 1'b0;
    end else begin
      if (wr_param) param_value <= host.wdata;
      if (wr_cmd) command_code <= host.wdata;
      command_strobe <= wr_cmd;
    end
  end

  // Threshold events and committed values to the outside
  // registered crossing events
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prox2_event  <= 1'b0;
      prox3_event  <= 1'b0;
      prox2_active <= {prox_regs_pkg::RESET_HIGH, prox_regs_pkg::RESET_LOW};
      prox3_active <= {prox_regs_pkg::RESET_HIGH, prox_regs_pkg::RESET_LOW};
    end else begin
      prox2_event  <= over[0];
      prox3_event  <= over[1];
      prox2_active <= active[0];
      prox3_active <= active[1];
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_pair_done2;
    wr_high[0] && pend_low[0];
  endsequence

  sequence s_lone_low2;
    wr_low[0] && !pend_high[0];
  endsequence

  property p_pair_apply;
    @(posedge clock) disable iff (!arst_n)
    s_pair_done2 |=> ##1
      prox2_active == {$past(host.wdata, 2), $past(th_low[0], 2)};
  endproperty
  a_pair_apply: assert property (p_pair_apply)
    else $error("channel two pair not applied");

  property p_lone_hold;
    @(posedge clock) disable iff (!arst_n)
    s_lone_low2 |=> ##1 $stable(prox2_active);
  endproperty
  a_lone_hold: assert property (p_lone_hold)
    else $error("half threshold reached comparator");

  property p_event2;
    @(posedge clock) disable iff (!arst_n)
    (meas.valid && meas.channel == prox_regs_pkg::CHAN_TWO &&
     meas.value > active[0]) |=> prox2_event;
  endproperty
  a_event2: assert property (p_event2)
    else $error("channel two event missing");

  property p_no_event2;
    @(posedge clock) disable iff (!arst_n)
    !(meas.valid && meas.channel == prox_regs_pkg::CHAN_TWO) |=> !prox2_event;
  endproperty
  a_no_event2: assert property (p_no_event2)
    else $error("spurious channel two event");

  property p_event3;
    @(posedge clock) disable iff (!arst_n)
    (meas.valid && meas.channel == prox_regs_pkg::CHAN_THREE) |=>
      prox3_event == ($past(meas.value) > $past(active[1]));
  endproperty
  a_event3: assert property (p_event3)
    else $error("channel three event wrong");

  property p_param;
    @(posedge clock) disable iff (!arst_n)
    wr_param |=> param_value == $past(host.wdata);
  endproperty
  a_param: assert property (p_param)
    else $error("parameter mailbox not written");

  property p_command;
    @(posedge clock) disable iff (!arst_n)
    wr_cmd |=> command_strobe && command_code == $past(host.wdata);
  endproperty
  a_command: assert property (p_command)
    else $error("command not delivered");

  property p_read_high2;
    @(posedge clock) disable iff (!arst_n)
    (host.read && host.addr == prox_regs_pkg::OFS_PROX2_HIGH) |=>
      rd_valid && rd_data == $past(th_high[0]);
  endproperty
  a_read_high2: assert property (p_read_high2)
    else $error("channel two high byte read wrong");

  property p_write_read3;
    @(posedge clock) disable iff (!arst_n)
    (wr_low[1] && !host.read) ##1 (host.read && !host.write &&
      host.addr == prox_regs_pkg::OFS_PROX3_LOW) |=>
      rd_data == $past(host.wdata, 2);
  endproperty
  a_write_read3: assert property (p_write_read3)
    else $error("channel three low byte lost");

  property p_read_low2;
    @(posedge clock) disable iff (!arst_n)
    (host.read && host.addr == prox_regs_pkg::OFS_PROX2_LOW) |=>
      rd_data == $past(th_low[0]);
  endproperty
  a_read_low2: assert property (p_read_low2)
    else $error("channel two low byte read wrong");

endmodule

// >>> host_model.sv
module host_model (
  input  wire logic                  clock,
  input  wire logic [7:0]            rd_data,
  input  wire logic                  rd_valid,
  output prox_regs_pkg::reg_access_t host
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pause code for the sequencer; value is arbitrary
  localparam logic [7:0] PAUSE_CMD = 8'h0b;

  initial host = '0;

  // ----------------------------------------------------------
  // Byte accesses
  // ----------------------------------------------------------
  // Release inverts the lines so stale values never look valid
  task automatic drive(input logic w, input logic [7:0] a, d);
    @(posedge clock);
    host <= {w, ~w, a, d};
    @(posedge clock);
    host <= {2'b00, ~a, ~d};
  endtask

  task automatic wr(input logic [7:0] a, d);
    drive(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    drive(1'b0, a, 8'h00);
    @(negedge clock);
    d = rd_data;
    v = rd_valid;
  endtask

  // Write then read back with no idle cycle between them
  task automatic wr_rd(input logic [7:0] a, d, output logic [7:0] q,
                       output logic v);
    @(posedge clock);
    host <= {2'b10, a, d};
    @(posedge clock);
    host <= {2'b01, a, ~d};
    @(posedge clock);
    host <= {2'b00, ~a, d};
    @(negedge clock);
    q = rd_data;
    v = rd_valid;
  endtask

  // ----------------------------------------------------------
  // Threshold update
  // ----------------------------------------------------------
  // pause, then bytes
  task automatic set_th(input logic [7:0] lo_a, input logic [15:0] t);
    wr(prox_regs_pkg::OFS_COMMAND, PAUSE_CMD);
    wr(lo_a, t[7:0]);
    wr(lo_a + 8'h01, t[15:8]);
  endtask
endmodule

// >>> prox_threshold_param_regs_bench.sv
module prox_threshold_param_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                        clock = 1'b0;
  logic                        arst_n = 1'b0;
  prox_regs_pkg::reg_access_t  host;
  prox_regs_pkg::measurement_t meas = '0;
  logic [7:0]                  rd_data, param_value, command_code, d;
  logic                        rd_valid, prox2_event, prox3_event;
  logic                        command_strobe, v;
  logic [15:0]                 prox2_active, prox3_active;
  int                          errors = 0;
  int                          tests_run = 0;
  // Address, written byte, expected read-back
  logic [23:0] rows [8] = '{24'h13a5a5, 24'h145a5a, 24'h15c3c3,
    24'h163c3c, 24'h177e7e, 24'h180101, 24'h19ff00, 24'h12ff00};

  always #5 clock = ~clock;

  host_model u_host (.clock(clock), .rd_data(rd_data),
    .rd_valid(rd_valid), .host(host));

  prox_threshold_param_regs dut (.clock(clock), .arst_n(arst_n),
    .host(host), .rd_data(rd_data), .rd_valid(rd_valid), .meas(meas),
    .prox2_event(prox2_event), .prox3_event(prox3_event),
    .prox2_active(prox2_active), .prox3_active(prox3_active),
    .param_value(param_value), .command_code(command_code),
    .command_strobe(command_strobe));

  // ----------------------------------------------------------
  // Checks and verdict
  // ----------------------------------------------------------
  task automatic check(input logic [15:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, exp);
    check({15'h0, got}, {15'h0, exp});
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One result in, both event lines checked a cycle later
  task automatic send(input logic [1:0] ch, input logic [15:0] val,
                      input logic e2, e3);
    @(posedge clock);
    meas <= {1'b1, ch, val};
    @(posedge clock);
    meas <= {1'b0, ~ch, ~val};
    @(negedge clock);
    check_flag(prox2_event, e2);
    check_flag(prox3_event, e3);
  endtask

  // Run needs under two hundred cycles; far more means a hang
  initial begin
    #50000;
    errors++;
    final_report();
  end

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    foreach (rows[i]) begin
      u_host.wr(rows[i][23:16], rows[i][15:8]);
      u_host.rd(rows[i][23:16], d, v);
      check_flag(v, 1'b1);
      check({8'h0, d}, {8'h0, rows[i][7:0]});
    end
    check(prox2_active, 16'h5aa5);
    check(prox3_active, 16'h3cc3);
    check({8'h0, param_value}, 16'h007e);
    $display("test register rows done");
    // Lone low byte must wait for its partner
    u_host.wr(prox_regs_pkg::OFS_PROX2_LOW, 8'h00);
    repeat (3) @(negedge clock);
    check(prox2_active, 16'h5aa5);
    send(prox_regs_pkg::CHAN_TWO, 16'h5aa5, 1'b0, 1'b0);
    send(prox_regs_pkg::CHAN_TWO, 16'h5aa6, 1'b1, 1'b0);
    u_host.wr(prox_regs_pkg::OFS_PROX2_HIGH, 8'h10);
    repeat (3) @(negedge clock);
    check(prox2_active, 16'h1000);
    send(prox_regs_pkg::CHAN_TWO, 16'h1001, 1'b1, 1'b0);
    send(prox_regs_pkg::CHAN_THREE, 16'h3cc4, 1'b0, 1'b1);
    send(2'h1, 16'hffff, 1'b0, 1'b0);
    $display("test commit and compare done");
    u_host.wr(prox_regs_pkg::OFS_COMMAND, 8'h42);
    @(negedge clock);
    check_flag(command_strobe, 1'b1);
    check({8'h0, command_code}, 16'h0042);
    @(negedge clock);
    check_flag(command_strobe, 1'b0);
    u_host.set_th(prox_regs_pkg::OFS_PROX3_LOW, 16'h0100);
    repeat (3) @(negedge clock);
    check({8'h0, command_code}, {8'h0, u_host.PAUSE_CMD});
    check(prox3_active, 16'h0100);
    send(prox_regs_pkg::CHAN_THREE, 16'h0100, 1'b0, 1'b0);
    // High byte first, then low byte read back in the next cycle
    u_host.wr(prox_regs_pkg::OFS_PROX3_HIGH, 8'h12);
    u_host.wr_rd(prox_regs_pkg::OFS_PROX3_LOW, 8'h34, d, v);
    check_flag(v, 1'b1);
    check({8'h0, d}, 16'h0034);
    repeat (2) @(negedge clock);
    check(prox3_active, 16'h1234);
    $display("test paused update done");
    // Second reset in mid-run clears every byte
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      u_host.rd(rows[i][23:16], d, v);
      check({8'h0, d}, 16'h0000);
    end
    check(prox3_active, 16'h0000);
    $display("test reset values done");
    final_report();
  end
endmodule
